// >>> rstr_pkg.sv
/*
  Constants, field layouts and types for the status, control and charger
  register block of a serial real-time clock.
  Assumes every design module imports the whole package.
*/
package rstr_pkg;

  typedef enum logic [1:0] {
    RSTR_VAR_IRQ_MODE_SELECT,
    RSTR_VAR_STORAGE,
    RSTR_VAR_SQW_PIN
  } rstr_variant_t;

  // register indices, low nibble of the address byte
  localparam logic [3:0] RSTR_CTRL_IDX   = 4'hd;
  localparam logic [3:0] RSTR_STATUS_IDX = 4'he;
  localparam logic [3:0] RSTR_CHARGE_IDX = 4'hf;
  localparam int         RSTR_DIR_BIT    = 7;

  // values after reset
  localparam logic [7:0] RSTR_CTRL_RESET   = 8'h18;
  localparam logic [7:0] RSTR_STATUS_RESET = 8'h80;
  localparam logic [7:0] RSTR_CHARGE_RESET = 8'h00;

  // writable or readable bits
  localparam logic [7:0] RSTR_CTRL_MASK   = 8'hbd;
  localparam logic [7:0] RSTR_STATUS_MASK = 8'h81;

  // control fields
  localparam int RSTR_OSC_STOP_BIT = 7;
  localparam int RSTR_BATT_OUT_BIT = 5;
  localparam int RSTR_RATE_HI_BIT  = 4;
  localparam int RSTR_RATE_LO_BIT  = 3;
  localparam int RSTR_MODE_BIT     = 2;
  localparam int RSTR_AIE_BIT      = 0;

  // status fields
  localparam int RSTR_OSF_BIT = 7;
  localparam int RSTR_AF_BIT  = 0;

  // charger fields and codes
  localparam logic [3:0] RSTR_CHARGE_KEY = 4'ha;
  localparam logic [1:0] RSTR_DIODE_NONE = 2'h1;
  localparam logic [1:0] RSTR_DIODE_ONE  = 2'h2;
  localparam logic [1:0] RSTR_RES_OFF    = 2'h0;

  localparam int RSTR_SYNC_STAGES = 2;

  // charger is live only with key, legal diode code and a resistor
  function automatic logic rstr_charge_ok(input logic [7:0] cfg);
    return (cfg[7:4] == RSTR_CHARGE_KEY) &&
           ((cfg[3:2] == RSTR_DIODE_NONE) || (cfg[3:2] == RSTR_DIODE_ONE)) &&
           (cfg[1:0] != RSTR_RES_OFF);
  endfunction

endpackage

// >>> rstr_link_if.sv
/*
  Carrier between the serial link logic and the register logic.
  Assumes the register side holds the read copies steady during a frame.
*/
`timescale 1ns/100ps
interface rstr_link_if;
  logic       link_rst;
  logic       wr_tgl;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_ctrl;
  logic [7:0] rd_status;
  logic [7:0] rd_charge;

  modport link (
    input  link_rst,
    input  rd_ctrl,
    input  rd_status,
    input  rd_charge,
    output wr_tgl,
    output wr_idx,
    output wr_data
  );

  modport regs (
    output link_rst,
    output rd_ctrl,
    output rd_status,
    output rd_charge,
    input  wr_tgl,
    input  wr_idx,
    input  wr_data
  );
endinterface

// >>> rstr_sync.sv
/*
  Two-stage level synchroniser, one per bit.
  Assumes each bit is an independent level.
*/
`timescale 1ns/100ps
module rstr_sync import rstr_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// >>> rstr_link.sv
/*
  Serial link shifter on the host clock.
  Assumes chip select high ends a frame and the host clock is idle outside it.
*/
`timescale 1ns/100ps
module rstr_link import rstr_pkg::*; #(
  parameter bit CPOL = 1'b0,
  parameter bit CPHA = 1'b1
) (
  // serial pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  // register side
  rstr_link_if.link bus
);
  localparam bit SAMPLE_FALL = (CPOL != CPHA);

  logic       sample_clk;
  logic [2:0] bit_cnt_reg;
  logic [7:0] in_sr_reg;
  logic [7:0] in_next;
  logic       have_addr_reg;
  logic       is_read_reg;
  logic [3:0] ptr_reg;
  logic [7:0] out_sr_reg;
  logic [7:0] rd_byte;

  // capture edge follows the polarity/phase pair
  assign sample_clk = SAMPLE_FALL ? ~sclk : sclk;
  assign in_next    = {in_sr_reg[6:0], sdi};

  always_comb begin
    unique case (ptr_reg)
      RSTR_CTRL_IDX:   rd_byte = bus.rd_ctrl;
      RSTR_STATUS_IDX: rd_byte = bus.rd_status;
      RSTR_CHARGE_IDX: rd_byte = bus.rd_charge;
      default:         rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sample_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg   <= 3'h0;
      in_sr_reg     <= 8'h00;
      have_addr_reg <= 1'b0;
      is_read_reg   <= 1'b0;
      ptr_reg       <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (!is_read_reg) begin
        in_sr_reg <= in_next;
      end
      if (bit_cnt_reg == 3'h7) begin
        if (!have_addr_reg) begin
          have_addr_reg <= 1'b1;
          is_read_reg   <= ~in_next[RSTR_DIR_BIT];
          ptr_reg       <= in_next[3:0];
        end else begin
          ptr_reg <= ptr_reg + 4'h1;
        end
      end
    end
  end

  // write event outlives the frame, so only the register reset clears it
  always_ff @(posedge sample_clk or posedge bus.link_rst) begin
    if (bus.link_rst) begin
      bus.wr_tgl  <= 1'b0;
      bus.wr_idx  <= 4'h0;
      bus.wr_data <= 8'h00;
    end else if (!cs_n && bit_cnt_reg == 3'h7 && have_addr_reg &&
                 !is_read_reg) begin
      bus.wr_tgl  <= ~bus.wr_tgl;
      bus.wr_idx  <= ptr_reg;
      bus.wr_data <= in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(negedge sample_clk or posedge cs_n) begin
    if (cs_n) begin
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
      out_sr_reg <= 8'h00;
    end else if (have_addr_reg && is_read_reg) begin
      sdo_oe <= 1'b1;
      if (bit_cnt_reg == 3'h0) begin
        sdo        <= rd_byte[7];
        out_sr_reg <= {rd_byte[6:0], 1'b0};
      end else begin
        sdo        <= out_sr_reg[7];
        out_sr_reg <= {out_sr_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// >>> rtc_status_trickle_regs.sv
/*
  Control, status and charger registers of a serial real-time clock,
  with the host serial link on its own clock domain.
  Assumes the oscillator monitor and square-wave taps arrive asynchronously
  and the alarm match pulse comes from logic on sys_clk.
*/
`timescale 1ns/100ps
module rtc_status_trickle_regs import rstr_pkg::*; #(
  parameter rstr_variant_t VARIANT = RSTR_VAR_IRQ_MODE_SELECT,
  parameter bit            CPOL    = 1'b0,
  parameter bit            CPHA    = 1'b1
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // timekeeping side
  input  wire logic       osc_running,
  input  wire logic       alarm_match,
  input  wire logic [3:0] rate_taps,
  // pins and charger controls
  output logic            wave_or_irq_out,
  output logic            square_wave_out,
  output logic            alarm_irq_out,
  output logic            osc_battery_stop,
  output logic            battery_output_enable,
  output logic            charge_enable,
  output logic            charge_diode_on,
  output logic [1:0]      charge_resistor_sel
);

  rstr_link_if bus ();

  logic [7:0] ctrl_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] charge_reg;
  logic       link_rst_reg;
  logic       tgl_sync;
  logic       tgl_seen_reg;
  logic       wr_event;
  logic       cs_sel_sync;
  logic       cs_sel_seen_reg;
  logic       frame_open;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_charge;
  logic       osc_sync;
  logic       osc_seen_reg;
  logic       osc_stop_edge;
  logic [3:0] taps_sync;
  logic       wave_sel;
  logic       irq_active;

  ////////////////////////////////////////////////////////////////////////
  // link side

  rstr_link #(
    .CPOL (CPOL),
    .CPHA (CPHA)
  ) u_link (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .sdi    (sdi),
    .sdo    (sdo),
    .sdo_oe (sdo_oe),
    .bus    (bus.link)
  );

  always_ff @(posedge sys_clk) begin
    link_rst_reg <= ~rst_n;
  end

  assign bus.link_rst = link_rst_reg;

  ////////////////////////////////////////////////////////////////////////
  // crossings into sys_clk

  rstr_sync #(
    .WIDTH (1)
  ) u_sync_tgl (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (bus.wr_tgl),
    .q     (tgl_sync)
  );

  rstr_sync #(
    .WIDTH (1)
  ) u_sync_cs (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (~cs_n),
    .q     (cs_sel_sync)
  );

  rstr_sync #(
    .WIDTH (1)
  ) u_sync_osc (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (osc_running),
    .q     (osc_sync)
  );

  rstr_sync #(
    .WIDTH (4)
  ) u_sync_taps (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (rate_taps),
    .q     (taps_sync)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tgl_seen_reg  <= 1'b0;
      cs_sel_seen_reg <= 1'b0;
      osc_seen_reg  <= 1'b0;
    end else begin
      tgl_seen_reg  <= tgl_sync;
      cs_sel_seen_reg <= cs_sel_sync;
      osc_seen_reg  <= osc_sync;
    end
  end

  // write data is steady for eight host clocks after the toggle
  assign wr_event      = tgl_sync ^ tgl_seen_reg;
  assign osc_stop_edge = osc_seen_reg & ~osc_sync;
  assign frame_open    = cs_sel_sync & ~cs_sel_seen_reg;

  ////////////////////////////////////////////////////////////////////////
  // write strobes, one per register

  function automatic logic rstr_wr_hit(input logic       strobe,
                                       input logic [3:0] idx,
                                       input logic [3:0] want);
    return strobe && (idx == want);
  endfunction

  assign wr_ctrl   = rstr_wr_hit(wr_event, bus.wr_idx, RSTR_CTRL_IDX);
  assign wr_status = rstr_wr_hit(wr_event, bus.wr_idx, RSTR_STATUS_IDX);
  assign wr_charge = rstr_wr_hit(wr_event, bus.wr_idx, RSTR_CHARGE_IDX);

  ////////////////////////////////////////////////////////////////////////
  // read copies, refreshed as a frame opens and steady through it

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus.rd_ctrl   <= 8'h00;
      bus.rd_status <= 8'h00;
      bus.rd_charge <= 8'h00;
    end else if (frame_open) begin
      bus.rd_ctrl   <= ctrl_reg;
      bus.rd_status <= status_reg & RSTR_STATUS_MASK;
      bus.rd_charge <= charge_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= RSTR_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= bus.wr_data & RSTR_CTRL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register: zero writes clear, set events win

  always_comb begin
    status_next = status_reg & RSTR_STATUS_MASK;
    if (wr_status) begin
      status_next = status_next & bus.wr_data;
    end
    if (osc_stop_edge) begin
      status_next[RSTR_OSF_BIT] = 1'b1;
    end
    if (alarm_match) begin
      status_next[RSTR_AF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_reg <= RSTR_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // charger register

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_reg <= RSTR_CHARGE_RESET;
    end else if (wr_charge) begin
      charge_reg <= bus.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_enable       <= 1'b0;
      charge_diode_on     <= 1'b0;
      charge_resistor_sel <= 2'h0;
    end else begin
      charge_enable       <= rstr_charge_ok(charge_reg);
      charge_diode_on     <= charge_reg[3:2] == RSTR_DIODE_ONE;
      charge_resistor_sel <= charge_reg[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pins

  assign wave_sel   = taps_sync[{ctrl_reg[RSTR_RATE_HI_BIT],
                                 ctrl_reg[RSTR_RATE_LO_BIT]}];
  assign irq_active = status_reg[RSTR_AF_BIT] & ctrl_reg[RSTR_AIE_BIT];

  // control bits mirrored to the oscillator and battery switches, battery switch held off in the storage variant
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_battery_stop      <= 1'b0;
      battery_output_enable <= 1'b0;
    end else begin
      osc_battery_stop      <= ctrl_reg[RSTR_OSC_STOP_BIT];
      battery_output_enable <= VARIANT != RSTR_VAR_STORAGE &&
                               ctrl_reg[RSTR_BATT_OUT_BIT];
    end
  end

  // combined pin, interrupt-control variant only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wave_or_irq_out <= 1'b0;
    end else if (VARIANT == RSTR_VAR_IRQ_MODE_SELECT) begin
      wave_or_irq_out <= ctrl_reg[RSTR_MODE_BIT] ?
                         irq_active : wave_sel;
    end else begin
      wave_or_irq_out <= 1'b0;
    end
  end

  // separate square pin, low bit 2 keeps it running
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      square_wave_out <= 1'b0;
    end else if (VARIANT == RSTR_VAR_SQW_PIN) begin
      square_wave_out <= ~ctrl_reg[RSTR_MODE_BIT] & wave_sel;
    end else begin
      square_wave_out <= 1'b0;
    end
  end

  // separate alarm pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_irq_out <= 1'b0;
    end else if (VARIANT == RSTR_VAR_SQW_PIN) begin
      alarm_irq_out <= irq_active;
    end else begin
      alarm_irq_out <= 1'b0;
    end
  end

endmodule

// >>> rstr_checker.sv
/*
  Port-level assertions for the status, control and charger registers.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module rstr_checker import rstr_pkg::*; #(
  parameter bit CPOL = 1'b0,
  parameter bit CPHA = 1'b1
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // serial link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  // control and charger outputs
  input wire logic       osc_battery_stop,
  input wire logic       battery_output_enable,
  input wire logic       charge_enable,
  input wire logic       charge_diode_on,
  input wire logic [1:0] charge_resistor_sel
);
  // sclk level right after a shift edge
  localparam bit SHIFT_LVL = CPOL ^ CPHA;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_idle;
    cs_n [*4];
  endsequence

  sequence s_oe_up;
    !sdo_oe ##1 sdo_oe;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  oe_off_deselect_a: assert property (cs_n [*2] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  oe_rise_select_a: assert property (s_oe_up |-> !cs_n)
    else $error("sdo enabled outside a frame");
  oe_rise_edge_a: assert property (s_oe_up |-> sclk == SHIFT_LVL)
    else $error("sdo enabled off the shift edge");
  sdo_hold_a: assert property (
    (!cs_n && sclk != SHIFT_LVL) [*2] |-> $stable(sdo))
    else $error("sdo moved without a shift edge");
  charge_needs_res_a: assert property (
    charge_enable |-> charge_resistor_sel != 2'h0)
    else $error("charger on with no resistor");
  charge_idle_hold_a: assert property (s_idle |->
    $stable(charge_enable) && $stable(charge_resistor_sel) &&
    $stable(charge_diode_on))
    else $error("charger changed with no write");
  reset_charge_off_a: assert property (disable iff (1'b0)
    !rst_n |=> !charge_enable && !charge_diode_on &&
    charge_resistor_sel == 2'h0)
    else $error("charger not off in reset");
  reset_ctrl_off_a: assert property (disable iff (1'b0)
    !rst_n |=> !osc_battery_stop && !battery_output_enable)
    else $error("control outputs not clear in reset");
endmodule

bind rtc_status_trickle_regs rstr_checker #(
  .CPOL (CPOL),
  .CPHA (CPHA)
) u_chk (
  .sys_clk               (sys_clk),
  .rst_n                 (rst_n),
  .sclk                  (sclk),
  .cs_n                  (cs_n),
  .sdo                   (sdo),
  .sdo_oe                (sdo_oe),
  .osc_battery_stop      (osc_battery_stop),
  .battery_output_enable (battery_output_enable),
  .charge_enable         (charge_enable),
  .charge_diode_on       (charge_diode_on),
  .charge_resistor_sel   (charge_resistor_sel)
);

// >>> rstr_host_model.sv
/*
  Behavioural host serial master, clock idle low, data launched on the rise.
  Assumes the device samples on the falling edge and shifts on the rise.
*/
`timescale 1ns/100ps
module rstr_host_model (
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [7:0] tx_q [4];
  logic [7:0] rx_q [4];
  logic       last_sdo;
  logic       wire_lvl;

  // released line shows the inverse of its last driven level
  assign wire_lvl = sdo_oe ? sdo : ~last_sdo;

  always @(negedge sclk) begin
    if (sdo_oe) begin
      last_sdo <= sdo;
    end
  end

  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b1;
    sdi      = 1'b0;
    last_sdo = 1'b0;
  end

  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      sdi  = tx[i];
      #32;
      sclk = 1'b0;
      rx[i] = wire_lvl;
      #32;
    end
  endtask

  task frame(input logic [7:0] addr, input int n);
    logic [7:0] junk;
    #0.7;
    cs_n = 1'b0;
    #64;
    xbyte(addr, junk);
    for (int k = 0; k < n; k++) begin
      xbyte(tx_q[k], rx_q[k]);
    end
    #32;
    cs_n = 1'b1;
    sdi  = ~sdi;
    #128;
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench for the status, control and charger registers.
  Assumes the host model drives the link and the checker is bound.
*/
`timescale 1ns/100ps
module tb_top;
  logic       sys_clk, rst_n, osc_running, alarm_match;
  logic [3:0] rate_taps;
  logic       sclk, cs_n, sdi, sdo, sdo_oe;
  logic       wave_or_irq_out, square_wave_out, alarm_irq_out;
  logic       osc_battery_stop, battery_output_enable;
  logic       charge_enable, charge_diode_on;
  logic [1:0] charge_resistor_sel;
  int         bad_count;
  int         cmp_count;

  rtc_status_trickle_regs dut (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .sclk                  (sclk),
    .cs_n                  (cs_n),
    .sdi                   (sdi),
    .sdo                   (sdo),
    .sdo_oe                (sdo_oe),
    .osc_running           (osc_running),
    .alarm_match           (alarm_match),
    .rate_taps             (rate_taps),
    .wave_or_irq_out       (wave_or_irq_out),
    .square_wave_out       (square_wave_out),
    .alarm_irq_out         (alarm_irq_out),
    .osc_battery_stop      (osc_battery_stop),
    .battery_output_enable (battery_output_enable),
    .charge_enable         (charge_enable),
    .charge_diode_on       (charge_diode_on),
    .charge_resistor_sel   (charge_resistor_sel)
  );

  rstr_host_model host (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .sdi    (sdi),
    .sdo    (sdo),
    .sdo_oe (sdo_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host.tx_q[0] = v;
    host.frame(8'h80 | idx, 1);
  endtask

  task automatic rd(input logic [7:0] idx, input int n);
    host.tx_q = '{8'hff, 8'h00, 8'ha5, 8'h5a};
    host.frame(idx, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rate_taps = 4'h8;
    cyc(8);
    chk("wave", 8'h01, {7'h0, wave_or_irq_out});
    rate_taps = 4'h7;
    cyc(8);
    chk("wave", 8'h00, {7'h0, wave_or_irq_out});
    chk("sqw", 8'h00, {7'h0, square_wave_out});
    chk("aint", 8'h00, {7'h0, alarm_irq_out});
    rd(8'h0d, 4);
    chk("ctrl", 8'h18, host.rx_q[0]);
    chk("stat", 8'h80, host.rx_q[1]);
    chk("chg", 8'h00, host.rx_q[2]);
    chk("wrap", 8'h00, host.rx_q[3]);
  endtask

  task automatic t_ctrl();
    wr(8'h0d, 8'hff);
    rd(8'h0d, 1);
    chk("ctrl", 8'hbd, host.rx_q[0]);
    chk("stop", 8'h01, {7'h0, osc_battery_stop});
    chk("bbout", 8'h01, {7'h0, battery_output_enable});
  endtask

  task automatic t_osf();
    wr(8'h0e, 8'h00);
    wr(8'h0e, 8'h81);
    rd(8'h0e, 1);
    chk("stat", 8'h00, host.rx_q[0]);
    cyc(1);
    osc_running = 1'b0;
    cyc(8);
    rd(8'h0e, 1);
    chk("stat", 8'h80, host.rx_q[0]);
    wr(8'h0e, 8'h00);
    rd(8'h0e, 1);
    chk("stat", 8'h00, host.rx_q[0]);
    cyc(1);
    osc_running = 1'b1;
  endtask

  task automatic t_alarm();
    wr(8'h0d, 8'h05);
    cyc(1);
    alarm_match = 1'b1;
    cyc(1);
    alarm_match = 1'b0;
    cyc(4);
    chk("irq", 8'h01, {7'h0, wave_or_irq_out});
    wr(8'h0e, 8'h81);
    rd(8'h0e, 1);
    chk("stat", 8'h01, host.rx_q[0]);
    wr(8'h0e, 8'h00);
    rd(8'h0e, 1);
    chk("stat", 8'h00, host.rx_q[0]);
    chk("irq", 8'h00, {7'h0, wave_or_irq_out});
    cyc(1);
    alarm_match = 1'b1;
    wr(8'h0e, 8'h00);
    cyc(1);
    alarm_match = 1'b0;
    wr(8'h0d, 8'h04);
    chk("irq", 8'h00, {7'h0, wave_or_irq_out});
    rd(8'h0e, 1);
    chk("stat", 8'h01, host.rx_q[0]);
  endtask

  task automatic t_charge();
    logic [7:0] tbl [11] = '{8'ha5, 8'ha9, 8'ha6, 8'haa, 8'ha7, 8'hab,
                             8'ha1, 8'had, 8'ha4, 8'hb5, 8'h00};
    logic [7:0] v;
    logic       e;
    foreach (tbl[i]) begin
      v = tbl[i];
      e = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) &&
          v[1:0] != 2'h0;
      wr(8'h0f, v);
      rd(8'h0f, 1);
      chk("chg", v, host.rx_q[0]);
      chk("en", {7'h0, e}, {7'h0, charge_enable});
      chk("dio", {7'h0, v[3:2] == 2'h2}, {7'h0, charge_diode_on});
      chk("res", {6'h0, v[1:0]}, {6'h0, charge_resistor_sel});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count   = 0;
    cmp_count   = 0;
    rst_n       = 1'b0;
    osc_running = 1'b1;
    alarm_match = 1'b0;
    rate_taps   = 4'h0;
    cyc(8);
    rst_n = 1'b1;
    t_reset();
    t_ctrl();
    t_osf();
    t_alarm();
    t_charge();
    give_verdict();
  end

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
